// >>> verilog/mclk_pkg.sv
// Constants, register map and state types of the master clock generator
package mclk_pkg;
  // ==========================================================================
  // Register map
  localparam logic [7:0] DIVISOR_OFFSET = 8'h00;
  localparam logic [7:0] STROBE_OFFSET = 8'h04;
  localparam logic [7:0] STATUS_OFFSET = 8'h08;
  localparam logic [7:0] TIMER_CTRL_OFFSET = 8'h0c;
  localparam logic [7:0] WAKE_TIME_OFFSET = 8'h10;
  localparam logic [7:0] TIMER_COUNT_OFFSET = 8'h14;
  // ==========================================================================
  // Fields
  localparam int DIV_W = 5;
  localparam logic [DIV_W-1:0] DIV_MIN = 5'h02;
  localparam logic [DIV_W-1:0] DIV_MAX = 5'h10;
  localparam logic [DIV_W-1:0] DIV_RESET = 5'h10;
  localparam int STROBE_FAST_BIT = 0;
  localparam int STROBE_SLOW_BIT = 1;
  localparam int STATUS_SRC_BIT = 0;
  localparam int STATUS_SWITCHING_BIT = 1;
  localparam int STATUS_FALLBACK_BIT = 2;
  localparam int STATUS_WAKE_BIT = 3;
  localparam int TIMER_EN_BIT = 0;
  localparam int TIMER_W = 24;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================================
  // Timing in source edges
  localparam logic [1:0] MISSING_LF_CYCLES = 2'h2;
  localparam logic [1:0] SYNC_EDGES = 2'h2;
  typedef enum logic [1:0] {
    SW_RUN = 2'b00,
    SW_DRAIN = 2'b01,
    SW_WAIT = 2'b10
  } switch_state_t;
endpackage : mclk_pkg

// >>> verilog/sleep_timer_if.sv
// Link between the clock generator and its sleep interval timer
`timescale 1ns/1ps
interface sleep_timer_if;
  import mclk_pkg::*;
  logic enable;
  logic restart;
  logic lf_tick;
  logic hit;
  logic [TIMER_W-1:0] wake_time;
  logic [TIMER_W-1:0] count;
  modport ctrl (output enable, output restart, output lf_tick, output wake_time,
                input count, input hit);
  modport timer (input enable, input restart, input lf_tick, input wake_time,
                 output count, output hit);
endinterface : sleep_timer_if

// >>> verilog/sleep_interval_timer.sv
// Sleep interval timer counting low-frequency clock cycles
`timescale 1ns/1ps
module sleep_interval_timer
  import mclk_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst,
  sleep_timer_if.timer tmr
);
  logic [TIMER_W-1:0] count;
  logic [TIMER_W-1:0] next_count;
  logic hit;
  logic next_hit;

  always_comb begin
    next_count = count;
    next_hit = 1'b0;
    if (tmr.restart) begin
      next_count = '0;
    end else if (tmr.enable && tmr.lf_tick) begin
      next_count = count + 24'h000001;
      next_hit = (next_count == tmr.wake_time);
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      count <= '0;
      hit <= 1'b0;
    end else begin
      count <= next_count;
      hit <= next_hit;
    end
  end

  assign tmr.count = count;
  assign tmr.hit = hit;

  // ==========================================================================
  // Checks
  a_timer_counts: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (tmr.enable && tmr.lf_tick && !tmr.restart) |=> count == $past(count) + 24'h000001)
    else $error("timer did not advance on a low-frequency tick");
  a_timer_hit: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    hit |-> count == $past(tmr.wake_time) && $past(tmr.lf_tick))
    else $error("wake-up hit without matching count");
endmodule : sleep_interval_timer

// >>> verilog/mac_master_clock_generator.sv
// Master clock generator: source switch, prescaler, reset fallback, register slave
//
// Chosen here: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
module mac_master_clock_generator
  import mclk_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_external_fast_clock_input,
  input wire logic i_low_frequency_clock,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [7:0] i_awaddr,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [7:0] i_araddr,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_master_clock,
  output logic o_companion_core_clock,
  output logic o_low_frequency_source,
  output logic o_wake_up
);
  function automatic logic [31:0] merge_lanes(input logic [31:0] old_val,
                                              input logic [31:0] new_val,
                                              input logic [3:0] strb);
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) res[i*8 +: 8] = new_val[i*8 +: 8];
    end
    return res;
  endfunction : merge_lanes

  // ==========================================================================
  // Pin synchronisers; a 50 MHz input still leaves 2.5 cycles per phase
  logic [1:0] pin_meta, pin_sync, pin_prev;
  logic fast_edge, lf_edge, lf_rise;

  always_ff @(posedge i_sys_clk) begin
    pin_meta <= {i_low_frequency_clock, i_external_fast_clock_input};
    pin_sync <= pin_meta;
    pin_prev <= pin_sync;
  end

  assign fast_edge = pin_sync[0] ^ pin_prev[0];
  assign lf_edge = pin_sync[1] ^ pin_prev[1];
  assign lf_rise = pin_sync[1] & ~pin_prev[1];

  // ==========================================================================
  // Missing fast clock detector, live only while reset is held
  logic rst_d;
  logic [1:0] miss_cnt, next_miss_cnt;
  logic fallback, next_fallback;

  always_comb begin
    next_miss_cnt = miss_cnt;
    next_fallback = fallback;
    if (i_rst && !rst_d) begin
      next_miss_cnt = '0;
      next_fallback = 1'b0;
    end else if (i_rst) begin
      if (fast_edge) begin
        next_miss_cnt = '0;
      end else if (lf_rise && miss_cnt != MISSING_LF_CYCLES) begin
        // Only low-frequency edges advance it, so no crystal means no fallback
        next_miss_cnt = miss_cnt + 2'h1;
      end
      if (next_miss_cnt == MISSING_LF_CYCLES) next_fallback = 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    rst_d <= i_rst;
    miss_cnt <= next_miss_cnt;
    fallback <= next_fallback;
  end

  // ==========================================================================
  // Register slave
  logic aw_have, next_aw_have;
  logic [7:0] aw_addr, next_aw_addr;
  logic w_have, next_w_have;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic awready, next_awready;
  logic wready, next_wready;
  logic bvalid, next_bvalid;
  logic [1:0] bresp, next_bresp;
  logic arready, next_arready;
  logic rvalid, next_rvalid;
  logic [31:0] rdata, next_rdata;
  logic [1:0] rresp, next_rresp;
  logic [DIV_W-1:0] div_reg, next_div_reg;
  logic timer_en, next_timer_en;
  logic [TIMER_W-1:0] wake_time, next_wake_time;
  logic wake, next_wake;
  logic wr_fire, strobe_fast, strobe_slow, timer_restart;
  logic [31:0] wr_div, wr_wake;
  logic src_lf, next_src_lf;
  switch_state_t sw_state, next_sw_state;
  sleep_timer_if tmr ();

  assign wr_fire = aw_have && w_have && !bvalid;
  assign strobe_fast = wr_fire && aw_addr == STROBE_OFFSET && w_strb[0]
                       && w_data[STROBE_FAST_BIT];
  assign strobe_slow = wr_fire && aw_addr == STROBE_OFFSET && w_strb[0]
                       && w_data[STROBE_SLOW_BIT];
  assign timer_restart = wr_fire && aw_addr == TIMER_CTRL_OFFSET && w_strb[0]
                         && w_data[TIMER_EN_BIT];
  assign wr_div = merge_lanes({27'h0, div_reg}, w_data, w_strb);
  assign wr_wake = merge_lanes({8'h00, wake_time}, w_data, w_strb);

  always_comb begin
    next_aw_have = aw_have | (i_awvalid & awready);
    next_aw_addr = (i_awvalid && awready) ? i_awaddr : aw_addr;
    next_w_have = w_have | (i_wvalid & wready);
    next_w_data = (i_wvalid && wready) ? i_wdata : w_data;
    next_w_strb = (i_wvalid && wready) ? i_wstrb : w_strb;
    next_bvalid = bvalid && !i_bready;
    next_bresp = bresp;
    next_div_reg = div_reg;
    next_timer_en = timer_en;
    next_wake_time = wake_time;
    next_wake = wake;
    if (wr_fire) begin
      next_aw_have = 1'b0;
      next_w_have = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = RESP_OKAY;
      case (aw_addr)
        DIVISOR_OFFSET: begin
          // Out-of-range divisors are ignored, keeping the old one
          if (wr_div[31:DIV_W] == 27'h0 && wr_div[DIV_W-1:0] >= DIV_MIN
              && wr_div[DIV_W-1:0] <= DIV_MAX) begin
            next_div_reg = wr_div[DIV_W-1:0];
          end
        end
        STROBE_OFFSET, TIMER_COUNT_OFFSET: ;
        STATUS_OFFSET: begin
          if (w_strb[0] && w_data[STATUS_WAKE_BIT]) next_wake = 1'b0;
        end
        TIMER_CTRL_OFFSET: begin
          if (w_strb[0]) next_timer_en = w_data[TIMER_EN_BIT];
        end
        WAKE_TIME_OFFSET: next_wake_time = wr_wake[TIMER_W-1:0];
        default: next_bresp = RESP_SLVERR;
      endcase
    end
    // Set wins over a clear in the same cycle
    if (tmr.hit) next_wake = 1'b1;
    next_awready = !next_aw_have;
    next_wready = !next_w_have;
    next_rvalid = rvalid && !i_rready;
    next_rdata = rdata;
    next_rresp = rresp;
    if (i_arvalid && arready) begin
      next_rvalid = 1'b1;
      next_rdata = '0;
      next_rresp = RESP_OKAY;
      case (i_araddr)
        DIVISOR_OFFSET: next_rdata[DIV_W-1:0] = div_reg;
        STROBE_OFFSET: ;
        STATUS_OFFSET: begin
          next_rdata[STATUS_SRC_BIT] = src_lf;
          next_rdata[STATUS_SWITCHING_BIT] = (sw_state != SW_RUN);
          next_rdata[STATUS_FALLBACK_BIT] = fallback;
          next_rdata[STATUS_WAKE_BIT] = wake;
        end
        TIMER_CTRL_OFFSET: next_rdata[TIMER_EN_BIT] = timer_en;
        WAKE_TIME_OFFSET: next_rdata[TIMER_W-1:0] = wake_time;
        TIMER_COUNT_OFFSET: next_rdata[TIMER_W-1:0] = tmr.count;
        default: next_rresp = RESP_SLVERR;
      endcase
    end
    next_arready = !next_rvalid;
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      aw_have <= 1'b0;
      aw_addr <= '0;
      w_have <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
      div_reg <= DIV_RESET;
      timer_en <= 1'b0;
      wake_time <= '0;
      wake <= 1'b0;
    end else begin
      aw_have <= next_aw_have;
      aw_addr <= next_aw_addr;
      w_have <= next_w_have;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      awready <= next_awready;
      wready <= next_wready;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      arready <= next_arready;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
      div_reg <= next_div_reg;
      timer_en <= next_timer_en;
      wake_time <= next_wake_time;
      wake <= next_wake;
    end
  end

  assign tmr.enable = timer_en;
  assign tmr.restart = timer_restart;
  assign tmr.lf_tick = lf_rise;
  assign tmr.wake_time = wake_time;

  sleep_interval_timer u_timer (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .tmr(tmr.timer)
  );

  // ==========================================================================
  // Source switch and prescaler
  // Counting both source edges gives half-integer steps; the master toggle halves them
  logic req_lf, next_req_lf;
  logic [1:0] sync_cnt, next_sync_cnt;
  logic [DIV_W-1:0] pre_cnt, next_pre_cnt;
  logic [DIV_W-1:0] div_act, next_div_act;
  logic master, next_master;
  logic companion, next_companion;
  logic sel_edge, end_hit, mid_hit;

  assign sel_edge = src_lf ? lf_edge : fast_edge;
  assign end_hit = sel_edge && pre_cnt == div_act - 5'h01;
  assign mid_hit = sel_edge && pre_cnt == (div_act >> 1) - 5'h01;

  always_comb begin
    next_req_lf = req_lf;
    next_src_lf = src_lf;
    next_sw_state = sw_state;
    next_sync_cnt = sync_cnt;
    next_pre_cnt = pre_cnt;
    next_div_act = div_act;
    next_master = master;
    next_companion = companion;
    if (strobe_slow) next_req_lf = 1'b1;
    else if (strobe_fast) next_req_lf = 1'b0;
    unique case (sw_state)
      SW_RUN, SW_DRAIN: begin
        if (sel_edge) begin
          next_pre_cnt = end_hit ? '0 : pre_cnt + 5'h01;
          if (mid_hit) next_companion = ~companion;
          if (end_hit) begin
            next_master = ~master;
            // New divisor only at the end of a whole period
            if (master) next_div_act = div_reg;
          end
        end
        if (req_lf == src_lf) begin
          next_sw_state = SW_RUN;
        end else if (sw_state == SW_RUN) begin
          next_sw_state = SW_DRAIN;
        end else if (sel_edge && !next_master && !next_companion) begin
          // Old source stops on its own edge with both outputs low
          next_src_lf = req_lf;
          next_sw_state = SW_WAIT;
          next_sync_cnt = '0;
          next_pre_cnt = '0;
        end
      end
      SW_WAIT: begin
        if (sel_edge) next_sync_cnt = sync_cnt + 2'h1;
        if (next_sync_cnt == SYNC_EDGES) next_sw_state = SW_RUN;
      end
      default: next_sw_state = SW_RUN;
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      req_lf <= next_fallback;
      src_lf <= next_fallback;
      sw_state <= SW_RUN;
      sync_cnt <= '0;
      pre_cnt <= '0;
      div_act <= DIV_RESET;
      master <= 1'b0;
      companion <= 1'b0;
    end else begin
      req_lf <= next_req_lf;
      src_lf <= next_src_lf;
      sw_state <= next_sw_state;
      sync_cnt <= next_sync_cnt;
      pre_cnt <= next_pre_cnt;
      div_act <= next_div_act;
      master <= next_master;
      companion <= next_companion;
    end
  end

  assign o_awready = awready;
  assign o_wready = wready;
  assign o_bvalid = bvalid;
  assign o_bresp = bresp;
  assign o_arready = arready;
  assign o_rvalid = rvalid;
  assign o_rdata = rdata;
  assign o_rresp = rresp;
  assign o_master_clock = master;
  assign o_companion_core_clock = companion;
  assign o_low_frequency_source = src_lf;
  assign o_wake_up = wake;

  // ==========================================================================
  // Checks
  default clocking @(posedge i_sys_clk); endclocking

  a_div_reset_value: assert property ($past(i_rst) |-> div_reg == 5'h10 && div_act == 5'h10)
    else $error("divisor not 16 after reset");
  a_div_in_range: assert property (disable iff (i_rst)
    $changed(div_reg) |-> div_reg >= DIV_MIN && div_reg <= DIV_MAX)
    else $error("divisor register out of range");
  a_div_at_period: assert property (disable iff (i_rst)
    (!$past(i_rst) && $changed(div_act)) |-> $fell(master))
    else $error("divisor changed mid period");
  a_toggle_on_edge: assert property (disable iff (i_rst)
    (!$past(i_rst) && $changed(master)) |-> $past(sel_edge))
    else $error("master toggled without a source edge");
  a_handover_quiet: assert property (disable iff (i_rst)
    sw_state == SW_WAIT |-> !master && !companion)
    else $error("clock active during handover");
  a_source_swap_low: assert property (disable iff (i_rst)
    (!$past(i_rst) && $changed(src_lf)) |-> $past(sel_edge) && !master && !companion
    ##1 sw_state == SW_WAIT)
    else $error("source changed with clocks active");
  a_fallback_latch: assert property ((i_rst && rst_d && miss_cnt == 2'h2) |=>
    fallback || (i_rst && !rst_d))
    else $error("fallback not latched at count two");
  a_fast_clears: assert property ((i_rst && rst_d && fast_edge) |=> miss_cnt == 2'h0)
    else $error("fast edge did not clear the count");
  a_lf_only: assert property ($rose(fallback) |-> $past(lf_rise))
    else $error("fallback without a low-frequency edge");
  a_reset_source: assert property (($past(i_rst) && !i_rst) |-> src_lf == fallback)
    else $error("source after reset does not follow detector");
  a_wake_sticky: assert property (disable iff (i_rst) tmr.hit |=> wake)
    else $error("wake flag not set on timer hit");

  c_to_slow: cover property (disable iff (i_rst) $rose(src_lf));
  c_to_fast: cover property (disable iff (i_rst) $fell(src_lf));
  c_fallback: cover property ($rose(fallback));
  c_div_change: cover property (disable iff (i_rst) $changed(div_act));
  c_wake: cover property (disable iff (i_rst) $rose(wake));
endmodule : mac_master_clock_generator

// >>> verif/clock_source_model.sv
// Behavioural model of the fast baseband clock and the low-frequency crystal
`timescale 1ns/1ps
module clock_source_model #(
  parameter real FAST_HALF_NS = 12.0,
  parameter real LF_HALF_NS = 200.0
) (
  input wire logic i_fast_run,
  input wire logic i_lf_run,
  output logic o_fast,
  output logic o_lf
);
  // ==========================================================================
  // Oscillators
  // Crystal sped up so that runs stay short; a stopped oscillator rests low
  initial begin
    o_fast = 1'b0;
    forever begin
      #(FAST_HALF_NS);
      o_fast = i_fast_run ? ~o_fast : 1'b0;
    end
  end
  initial begin
    o_lf = 1'b0;
    forever begin
      #(LF_HALF_NS);
      o_lf = i_lf_run ? ~o_lf : 1'b0;
    end
  end
endmodule : clock_source_model

// >>> verif/mac_master_clock_generator_test.sv
// Self-checking bench of the master clock generator
`timescale 1ns/1ps
module mac_master_clock_generator_test;
  import mclk_pkg::*;
  typedef struct packed {
    logic [1:0] resp;
    logic [31:0] data;
    logic [31:0] mask;
  } rd_note_t;
  logic clk, rst, fast_run, lf_run, fast, lf;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic awready, wready, bvalid, arready, rvalid, mclk, cclk, lf_src, wake;
  logic [1:0] bresp, rresp;
  int err_total = 0;
  int n_tests = 0;
  int n_rise = 0;
  int c_rise = 0;
  int i, d, k;
  rd_note_t rd_q[$];
  rd_note_t note;
  logic [1:0] wr_q[$];
  realtime t_rise = 0, period = 0, t_edge = 0, min_pw = 1.0e9;
  logic m_q = 1'b0;
  logic c_q = 1'b0;

  mac_master_clock_generator i_dut (.i_sys_clk(clk), .i_rst(rst),
    .i_external_fast_clock_input(fast), .i_low_frequency_clock(lf),
    .i_awvalid(awvalid), .o_awready(awready), .i_awaddr(awaddr), .i_wvalid(wvalid),
    .o_wready(wready), .i_wdata(wdata), .i_wstrb(wstrb), .o_bvalid(bvalid),
    .i_bready(bready), .o_bresp(bresp), .i_arvalid(arvalid), .o_arready(arready),
    .i_araddr(araddr), .o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata),
    .o_rresp(rresp), .o_master_clock(mclk), .o_companion_core_clock(cclk),
    .o_low_frequency_source(lf_src), .o_wake_up(wake));
  clock_source_model i_src (.i_fast_run(fast_run), .i_lf_run(lf_run), .o_fast(fast),
    .o_lf(lf));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ==========================================================================
  // Checking
  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Watches responses and clock edges; design outputs read before they update
  always @(posedge clk) begin
    if (rvalid === 1'b1 && rready === 1'b1) begin
      if (rd_q.size() > 0) begin
        note = rd_q.pop_front();
        chk({30'h0, rresp}, {30'h0, note.resp});
        chk(rdata & note.mask, note.data & note.mask);
      end else begin
        chk(32'h1, 32'h0);
      end
    end
    if (bvalid === 1'b1 && bready === 1'b1) begin
      chk({30'h0, bresp}, (wr_q.size() > 0) ? {30'h0, wr_q.pop_front()} : 32'hf);
    end
    if (rst === 1'b1) begin
      t_edge = 0;
      t_rise = 0;
    end else if (mclk !== m_q) begin
      if (t_edge > 0 && $realtime - t_edge < min_pw) min_pw = $realtime - t_edge;
      t_edge = $realtime;
      if (mclk === 1'b1) begin
        if (t_rise > 0) period = $realtime - t_rise;
        t_rise = $realtime;
        n_rise++;
      end
    end
    if (cclk === 1'b1 && c_q === 1'b0) c_rise++;
    m_q = mclk;
    c_q = cclk;
  end

  // ==========================================================================
  // Stimulus tasks, entered at a rising edge
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] dt, input logic [1:0] er);
    logic aw_ok, w_ok;
    wr_q.push_back(er);
    awaddr <= a;
    wdata <= dt;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    k = 0;
    while (!(aw_ok && w_ok) && k < 1000) begin
      @(posedge clk);
      k++;
      if (awvalid === 1'b1 && awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid === 1'b1 && wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1 && k < 1000) begin
      @(posedge clk);
      k++;
    end
    bready <= 1'b0;
    @(posedge clk);
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] dt, input logic [31:0] m,
                        input logic [1:0] er);
    rd_q.push_back(rd_note_t'{er, dt, m});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (arready !== 1'b1 && k < 1000);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1 && k < 1000) begin
      @(posedge clk);
      k++;
    end
    rready <= 1'b0;
    @(posedge clk);
  endtask : axi_rd

  task automatic do_reset(input int n);
    rst <= 1'b1;
    repeat (n) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : do_reset

  // Three master periods, then the last one against divisor times source period
  task automatic chk_period(input int dv, input real src);
    int n0, c0;
    n0 = n_rise;
    c0 = c_rise;
    k = 0;
    while (n_rise < n0 + 3 && k < 20000) begin
      @(posedge clk);
      k++;
    end
    chk({31'h0, period > dv * src - 8.0 && period < dv * src + 8.0}, 32'h1);
    chk({31'h0, c_rise - c0 >= 2}, 32'h1);
  endtask : chk_period

  task automatic wait_src(input logic v);
    k = 0;
    while (lf_src !== v && k < 3000) begin
      @(posedge clk);
      k++;
    end
    chk({31'h0, lf_src}, {31'h0, v});
  endtask : wait_src

  // ==========================================================================
  // Main sequence
  initial begin
    rst = 1'b0;
    fast_run = 1'b1;
    lf_run = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'h0;
    void'($urandom(61561));
    repeat (2) @(posedge clk);
    do_reset(10);
    do_reset(500);
    chk({31'h0, lf_src}, 32'h0);
    axi_rd(DIVISOR_OFFSET, 32'h10, 32'h1f, RESP_OKAY);
    chk_period(16, 24.0);
    axi_wr(DIVISOR_OFFSET, 32'h1, RESP_OKAY);
    axi_wr(DIVISOR_OFFSET, 32'h11, RESP_OKAY);
    axi_rd(DIVISOR_OFFSET, 32'h10, 32'h1f, RESP_OKAY);
    // Divisor 3 keeps the master clock near 13.9 MHz; divisor 2 follows for top rate
    for (i = 0; i < 6; i++) begin
      d = (i == 0) ? 3 : (i == 1) ? 2 : (i == 2) ? 16 : 2 + int'($urandom % 15);
      axi_wr(DIVISOR_OFFSET, 32'(d), RESP_OKAY);
      axi_rd(DIVISOR_OFFSET, 32'(d), 32'h1f, RESP_OKAY);
      chk_period(d, 24.0);
    end
    axi_wr(8'h20, 32'h0, RESP_SLVERR);
    axi_rd(8'h18, 32'h0, 32'hffffffff, RESP_SLVERR);
    axi_wr(TIMER_COUNT_OFFSET, 32'h5, RESP_OKAY);
    axi_rd(STROBE_OFFSET, 32'h0, 32'hffffffff, RESP_OKAY);
    axi_wr(DIVISOR_OFFSET, 32'h2, RESP_OKAY);
    axi_wr(STROBE_OFFSET, 32'h2, RESP_OKAY);
    wait_src(1'b1);
    // Read lands while the new source is still being synchronised
    axi_rd(STATUS_OFFSET, 32'h3, 32'h3, RESP_OKAY);
    chk_period(2, 400.0);
    axi_rd(STATUS_OFFSET, 32'h1, 32'h3, RESP_OKAY);
    // Sleep on the slow source, then restart the fast oscillator and time its settling
    fast_run <= 1'b0;
    repeat (50) @(posedge clk);
    fast_run <= 1'b1;
    axi_wr(WAKE_TIME_OFFSET, 32'h3, RESP_OKAY);
    axi_wr(TIMER_CTRL_OFFSET, 32'h1, RESP_OKAY);
    k = 0;
    while (wake !== 1'b1 && k < 3000) begin
      @(posedge clk);
      k++;
    end
    chk({31'h0, wake}, 32'h1);
    axi_wr(TIMER_CTRL_OFFSET, 32'h0, RESP_OKAY);
    axi_rd(TIMER_COUNT_OFFSET, 32'h3, 32'hffffff, RESP_OKAY);
    axi_wr(STATUS_OFFSET, 32'h8, RESP_OKAY);
    chk({31'h0, wake}, 32'h0);
    axi_wr(STROBE_OFFSET, 32'h1, RESP_OKAY);
    wait_src(1'b0);
    chk_period(2, 24.0);
    chk({31'h0, min_pw >= 16.0}, 32'h1);
    fast_run <= 1'b0;
    do_reset(600);
    chk({31'h0, lf_src}, 32'h1);
    axi_rd(STATUS_OFFSET, 32'h5, 32'h5, RESP_OKAY);
    axi_rd(DIVISOR_OFFSET, 32'h10, 32'h1f, RESP_OKAY);
    // Both sources silent: without slow edges the detector must stay quiet
    lf_run <= 1'b0;
    do_reset(600);
    chk({31'h0, lf_src}, 32'h0);
    axi_rd(STATUS_OFFSET, 32'h0, 32'h5, RESP_OKAY);
    fast_run <= 1'b1;
    chk_period(16, 24.0);
    chk(32'(rd_q.size() + wr_q.size()), 32'h0);
    final_report();
  end

  initial begin
    #380000;
    err_total++;
    final_report();
  end
endmodule : mac_master_clock_generator_test
